// file: jtag_tap_idcode.sv
// test access port controller with instruction, bypass and identification registers
`timescale 1ns/100ps

// Summary of operation
// - stay in test logic reset when functional
// - reset state loads IDCODE instruction
// - TRST low forces reset without TCK
// - 32-bit ID with manufacturer, part, version
// - IDCODE selects ID register TDI to TDO
// - capture loads ID code, then shifts out
// - bit 0 leaves TDO first, MSB at TDI
// - BYPASS puts one-bit register in path
// - CLAMP uses bypass, boundary stays external
module jtag_tap_idcode #(
    parameter logic [3:0]  ID_VERSION = 4'h1,    // arbitrary value
    parameter logic [15:0] ID_PART    = 16'h1234, // arbitrary value
    parameter logic [10:0] ID_MFR     = 11'h055  // arbitrary value
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic tck,
    input  wire logic tms,
    input  wire logic tdi,
    input  wire logic trstN,
    output logic      tdo,
    output logic      tdoOe,
    output logic      tapInReset,
    output logic      extestMode
);
    logic [jtag_tap_pkg::SYNC_W-1:0] sync1_q;
    logic [jtag_tap_pkg::SYNC_W-1:0] sync2_q;
    logic                            tckDly_q;
    logic                            tckRise;
    logic                            tckFall;
    logic                            forceReset;
    jtag_tap_pkg::tap_state_t        state_q;
    jtag_tap_pkg::tap_state_t        state_d;
    logic [jtag_tap_pkg::IR_W-1:0]   ir_q;
    logic [jtag_tap_pkg::IR_W-1:0]   irShift_q;
    logic [jtag_tap_pkg::ID_W-1:0]   idShift_q;
    logic                            bypass_q;
    logic                            selId;
    logic                            tdo_q;
    logic                            tdoOe_q;
    logic                            extest_q;
    logic [jtag_tap_pkg::ID_W-1:0]   idCode;
    logic                            tmsS;
    logic                            tdiS;

    // fixed identification word, mandatory one in bit 0
    always_comb begin
        idCode                                                       = 32'h0000_0001;
        idCode[jtag_tap_pkg::ID_W-1:jtag_tap_pkg::ID_VER_LSB]        = ID_VERSION;
        idCode[jtag_tap_pkg::ID_VER_LSB-1:jtag_tap_pkg::ID_PART_LSB] = ID_PART;
        idCode[jtag_tap_pkg::ID_PART_LSB-1:jtag_tap_pkg::ID_MFR_LSB] = ID_MFR;
    end

    // two-stage synchronisers for all test pins
    // the test clock is sampled as data, so it must run well below the system clock
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= jtag_tap_pkg::SYNC_RESET_VAL;
            sync2_q <= jtag_tap_pkg::SYNC_RESET_VAL;
        end else begin
            sync1_q <= {trstN, tdi, tms, tck};
            sync2_q <= sync1_q;
        end
    end

    // edge detector on the synchronised test clock
    // reset value matches the idle low level of the test clock, so no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            tckDly_q <= 1'b0;
        end else begin
            tckDly_q <= sync2_q[jtag_tap_pkg::S_TCK];
        end
    end

    // one-cycle strobes at each detected test clock edge
    assign tckRise    = sync2_q[jtag_tap_pkg::S_TCK] & ~tckDly_q;
    assign tckFall    = ~sync2_q[jtag_tap_pkg::S_TCK] & tckDly_q;

    // pin levels as seen at the detected edge
    assign tmsS       = sync2_q[jtag_tap_pkg::S_TMS];
    assign tdiS       = sync2_q[jtag_tap_pkg::S_TDI];

    // either reset source sends the controller home; test reset needs no test clock edge
    assign forceReset = rst | ~sync2_q[jtag_tap_pkg::S_TRST];

    // next state of the controller, advanced on each rising test clock
    always_comb begin
        state_d = state_q;
        case (state_q)
            jtag_tap_pkg::TEST_LOGIC_RESET: begin
                state_d = tmsS ? jtag_tap_pkg::TEST_LOGIC_RESET : jtag_tap_pkg::RUN_TEST_IDLE;
            end
            jtag_tap_pkg::RUN_TEST_IDLE: begin
                state_d = tmsS ? jtag_tap_pkg::SELECT_DR : jtag_tap_pkg::RUN_TEST_IDLE;
            end
            jtag_tap_pkg::SELECT_DR: begin
                state_d = tmsS ? jtag_tap_pkg::SELECT_IR : jtag_tap_pkg::CAPTURE_DR;
            end
            jtag_tap_pkg::CAPTURE_DR: begin
                state_d = tmsS ? jtag_tap_pkg::EXIT1_DR : jtag_tap_pkg::SHIFT_DR;
            end
            jtag_tap_pkg::SHIFT_DR: begin
                state_d = tmsS ? jtag_tap_pkg::EXIT1_DR : jtag_tap_pkg::SHIFT_DR;
            end
            jtag_tap_pkg::EXIT1_DR: begin
                state_d = tmsS ? jtag_tap_pkg::UPDATE_DR : jtag_tap_pkg::PAUSE_DR;
            end
            jtag_tap_pkg::PAUSE_DR: begin
                state_d = tmsS ? jtag_tap_pkg::EXIT2_DR : jtag_tap_pkg::PAUSE_DR;
            end
            jtag_tap_pkg::EXIT2_DR: begin
                state_d = tmsS ? jtag_tap_pkg::UPDATE_DR : jtag_tap_pkg::SHIFT_DR;
            end
            jtag_tap_pkg::UPDATE_DR: begin
                state_d = tmsS ? jtag_tap_pkg::SELECT_DR : jtag_tap_pkg::RUN_TEST_IDLE;
            end
            jtag_tap_pkg::SELECT_IR: begin
                state_d = tmsS ? jtag_tap_pkg::TEST_LOGIC_RESET : jtag_tap_pkg::CAPTURE_IR;
            end
            jtag_tap_pkg::CAPTURE_IR: begin
                state_d = tmsS ? jtag_tap_pkg::EXIT1_IR : jtag_tap_pkg::SHIFT_IR;
            end
            jtag_tap_pkg::SHIFT_IR: begin
                state_d = tmsS ? jtag_tap_pkg::EXIT1_IR : jtag_tap_pkg::SHIFT_IR;
            end
            jtag_tap_pkg::EXIT1_IR: begin
                state_d = tmsS ? jtag_tap_pkg::UPDATE_IR : jtag_tap_pkg::PAUSE_IR;
            end
            jtag_tap_pkg::PAUSE_IR: begin
                state_d = tmsS ? jtag_tap_pkg::EXIT2_IR : jtag_tap_pkg::PAUSE_IR;
            end
            jtag_tap_pkg::EXIT2_IR: begin
                state_d = tmsS ? jtag_tap_pkg::UPDATE_IR : jtag_tap_pkg::SHIFT_IR;
            end
            jtag_tap_pkg::UPDATE_IR: begin
                state_d = tmsS ? jtag_tap_pkg::SELECT_DR : jtag_tap_pkg::RUN_TEST_IDLE;
            end
            default: begin
                state_d = jtag_tap_pkg::TEST_LOGIC_RESET;
            end
        endcase
    end

    // controller state; test reset low acts on the system clock, no test clock edge needed
    // otherwise the state advances once per detected rising test clock
    always_ff @(posedge clk) begin
        if (forceReset) begin
            state_q <= jtag_tap_pkg::TEST_LOGIC_RESET;
        end else if (tckRise) begin
            state_q <= state_d;
        end
    end

    // instruction register and its shift stage
    // test logic reset reloads the default instruction on every clock it lasts
    always_ff @(posedge clk) begin
        if (forceReset || state_q == jtag_tap_pkg::TEST_LOGIC_RESET) begin
            ir_q      <= jtag_tap_pkg::IR_RESET_VAL;
            irShift_q <= jtag_tap_pkg::IR_CAPTURE_VAL;
        end else if (tckRise) begin
            case (state_q)
                jtag_tap_pkg::CAPTURE_IR: irShift_q <= jtag_tap_pkg::IR_CAPTURE_VAL;
                jtag_tap_pkg::SHIFT_IR:   irShift_q <= {tdiS, irShift_q[jtag_tap_pkg::IR_W-1:1]};
                jtag_tap_pkg::UPDATE_IR:  ir_q      <= irShift_q;
                default:                  irShift_q <= irShift_q;
            endcase
        end
    end

    // identification path only for IDCODE, every other instruction uses bypass
    // unknown codes fall back to the bypass register as well
    assign selId = (ir_q == jtag_tap_pkg::INS_IDCODE);

    // data registers: identification shifter and one-bit bypass
    always_ff @(posedge clk) begin
        if (forceReset) begin
            idShift_q <= jtag_tap_pkg::ID_RESET_VAL;
            bypass_q  <= 1'b0;
        end else if (tckRise) begin
            if (state_q == jtag_tap_pkg::CAPTURE_DR) begin
                idShift_q <= selId ? idCode : idShift_q;
                bypass_q  <= 1'b0;
            end else if (state_q == jtag_tap_pkg::SHIFT_DR) begin
                idShift_q <= {tdiS, idShift_q[jtag_tap_pkg::ID_W-1:1]};
                bypass_q  <= tdiS;
            end
        end
    end

    // boundary outputs held in external test mode under EXTEST and CLAMP
    always_ff @(posedge clk) begin
        if (forceReset) begin
            extest_q <= 1'b0;
        end else begin
            extest_q <= (ir_q == jtag_tap_pkg::INS_CLAMP) || (ir_q == jtag_tap_pkg::INS_EXTEST);
        end
    end

    // serial output changes only on falling test clock, driven in shift states
    // test reset releases tdo at once, without a falling test clock
    always_ff @(posedge clk) begin
        if (forceReset) begin
            tdo_q   <= 1'b0;
            tdoOe_q <= 1'b0;
        end else if (tckFall) begin
            tdoOe_q <= (state_q == jtag_tap_pkg::SHIFT_DR) || (state_q == jtag_tap_pkg::SHIFT_IR);
            if (state_q == jtag_tap_pkg::SHIFT_IR) begin
                tdo_q <= irShift_q[0];
            end else if (state_q == jtag_tap_pkg::SHIFT_DR) begin
                tdo_q <= selId ? idShift_q[0] : bypass_q;
            end
        end
    end

    // outputs straight from the registers and the state decode
    assign tdo        = tdo_q;
    assign tdoOe      = tdoOe_q;
    assign tapInReset = (state_q == jtag_tap_pkg::TEST_LOGIC_RESET);
    assign extestMode = extest_q;
endmodule

// file: jtag_tap_pkg.sv
// constants, states and instruction codes of the test access port
package jtag_tap_pkg;
    localparam int IR_W  = 4;
    localparam int ID_W  = 32;
    localparam int SYNC_W = 4;

    // instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
    localparam logic [IR_W-1:0] INS_SAMPLE = 4'h1;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
    localparam logic [IR_W-1:0] INS_CLAMP  = 4'h3;
    localparam logic [IR_W-1:0] INS_INTEST = 4'h4;
    localparam logic [IR_W-1:0] INS_USER1  = 4'h5;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;

    // values loaded at reset and capture
    localparam logic [IR_W-1:0] IR_RESET_VAL   = INS_IDCODE;
    localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 4'h8; // test reset inactive, test clock low
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 4'h1;
    localparam logic [ID_W-1:0] ID_RESET_VAL   = 32'h0000_0000;

    // identification field positions
    localparam int ID_VER_LSB  = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB  = 1;

    // synchroniser bit positions
    localparam int S_TCK  = 0;
    localparam int S_TMS  = 1;
    localparam int S_TDI  = 2;
    localparam int S_TRST = 3;

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET = 4'b1111,
        RUN_TEST_IDLE    = 4'b1100,
        SELECT_DR        = 4'b0111,
        CAPTURE_DR       = 4'b0110,
        SHIFT_DR         = 4'b0010,
        EXIT1_DR         = 4'b0001,
        PAUSE_DR         = 4'b0011,
        EXIT2_DR         = 4'b0000,
        UPDATE_DR        = 4'b0101,
        SELECT_IR        = 4'b0100,
        CAPTURE_IR       = 4'b1110,
        SHIFT_IR         = 4'b1010,
        EXIT1_IR         = 4'b1001,
        PAUSE_IR         = 4'b1011,
        EXIT2_IR         = 4'b1000,
        UPDATE_IR        = 4'b1101
    } tap_state_t;
endpackage

// file: jtag_tap_idcode_sva.sv
// checker for the test access port outputs
`timescale 1ns/100ps
module jtag_tap_idcode_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trstN,
    input wire logic tdo,
    input wire logic tdoOe,
    input wire logic tapInReset,
    input wire logic extestMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // reset places the controller home with tdo released
    a_sync_reset_home: assert property (disable iff (1'b0) rst |=> tapInReset && !tdoOe && !extestMode)
        else $error("sync reset not home");
    a_trst_forces_home: assert property (!trstN [*3] |=> tapInReset)
        else $error("test reset not home");
    a_trst_ir_default: assert property (!trstN [*5] |=> !extestMode)
        else $error("test reset kept extest");
    a_home_ir_default: assert property (tapInReset [*3] |-> !extestMode)
        else $error("home kept extest");
    a_leave_home_low: assert property ($fell(tapInReset) |-> !$past(tms, 3) && $past(tck, 3) && !$past(tck, 4))
        else $error("left home without tms low rise");
    a_tdo_on_fall: assert property ($changed(tdo) || $changed(tdoOe) |-> !$past(tck, 2) || !$past(tck, 3))
        else $error("tdo moved outside tck low");
    a_tdo_stands_high: assert property (tck [*3] |-> $stable(tdo) && $stable(tdoOe))
        else $error("tdo moved while tck high");
    a_oe_off_home: assert property ($fell(tck) && tapInReset |-> ##[4:6] !tdoOe)
        else $error("tdo driven outside shift");
    cover property ($fell(tapInReset));
    cover property ($rose(tdoOe));
    cover property ($rose(extestMode));
    cover property (tdoOe && $changed(tdi));
endmodule
bind jtag_tap_idcode jtag_tap_idcode_sva u_sva (.clk, .rst, .tck, .tms, .tdi, .trstN, .tdo, .tdoOe, .tapInReset,
    .extestMode);

// file: tap_master.sv
// board tester model driving the test access port pins
`timescale 1ns/100ps
module tap_master (
    input  wire logic clk,
    input  wire logic tdo,
    input  wire logic tdoOe,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trstN
);
    // test clock stands low outside frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trstN = 1'b1;
    end
    // one 900 ns test clock period, tdo sampled at the rise
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge clk);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        tck = 1'b1;
        q = tdoOe ? tdo : 1'b1; // released line floats to its pull-up
        repeat (4) @(negedge clk);
        tck = 1'b0;
        tdi = ~d; // released line does not keep its value
    endtask
    // test reset with the test clock still
    task automatic resetPulse();
        @(negedge clk);
        trstN = 1'b0;
        repeat (6) @(negedge clk);
        trstN = 1'b1;
        repeat (3) @(negedge clk);
    endtask
endmodule

// file: jtag_tap_idcode_logic_tb.sv
// self-checking bench for the test access port logic
`timescale 1ns/100ps
module jtag_tap_idcode_logic_tb;
    localparam logic [31:0] ID_EXP = {4'h3, 16'h5a6c, 11'h2b1, 1'h1}; // arbitrary identity
    typedef struct {logic e; string n;} note_t;
    logic clk, rst, tck, tms, tdi, trstN, tdo, tdoOe, tapInReset, extestMode, gotV, q;
    note_t noteQ[$];
    event resEv;
    int bad_count = 0;
    int tests_run = 0;
    logic [7:0] seed = 8'h44;
    logic [3:0] codes[7] = '{4'hf, 4'h3, 4'h1, 4'h4, 4'h5, 4'h9, 4'h0};
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    jtag_tap_idcode #(.ID_VERSION(4'h3), .ID_PART(16'h5a6c), .ID_MFR(11'h2b1)) u_jtag_tap_idcode (.clk, .rst, .tck,
        .tms, .tdi, .trstN, .tdo, .tdoOe, .tapInReset, .extestMode);
    tap_master u_tap_master (.clk, .tdo, .tdoOe, .tck, .tms, .tdi, .trstN);
    // next value of the stimulus shift register
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // note the expectation, then publish what was seen
    task automatic obs(input logic e, input logic v, input string n);
        noteQ.push_back(note_t'{e, n});
        gotV = v;
        -> resEv;
        #1;
    endtask
    task automatic check(input logic seen, input logic exp, input string n);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", n, exp, seen);
        end
    endtask
    // monitor pairs each published result with the oldest note
    initial forever begin
        @(resEv);
        check(gotV, noteQ[0].e, noteQ[0].n);
        void'(noteQ.pop_front());
    end
    // from idle, scan n bits through a len-bit register captured as cap
    task automatic drScan(input int len, input logic [31:0] cap, input int n);
        logic [31:0] m;
        m = cap;
        u_tap_master.step(1'b1, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            seed = lfsr(seed);
            u_tap_master.step(i == n - 1, seed[0], q);
            obs(m[0], q, "tdo");
            obs(1'b1, tdoOe, "tdoOe");
            m = m >> 1;
            m[len - 1] = seed[0];
        end
        u_tap_master.step(1'b1, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        obs(1'b0, tdoOe, "tdoOeIdle");
    endtask
    // from idle, shift an instruction in lsb first
    task automatic irLoad(input logic [3:0] c);
        u_tap_master.step(1'b1, 1'b0, q);
        u_tap_master.step(1'b1, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        for (int i = 0; i < 4; i++) begin
            u_tap_master.step(i == 3, c[i], q);
            obs(i == 0, q, "irCapture");
        end
        u_tap_master.step(1'b1, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        obs(c == jtag_tap_pkg::INS_EXTEST || c == jtag_tap_pkg::INS_CLAMP, extestMode, "extestMode");
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
    initial begin
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        obs(1'b1, tapInReset, "tapInReset");
        u_tap_master.step(1'b0, 1'b0, q);
        drScan(32, ID_EXP, 40);
        $display("test identity after reset done");
        foreach (codes[k]) begin
            irLoad(codes[k]);
            drScan(1, 32'h0, 4);
        end
        $display("test instruction paths done");
        repeat (5) u_tap_master.step(1'b1, 1'b0, q);
        obs(1'b1, tapInReset, "tapInReset");
        obs(1'b0, extestMode, "extestMode");
        u_tap_master.step(1'b0, 1'b0, q);
        drScan(32, ID_EXP, 32);
        $display("test tms return home done");
        irLoad(jtag_tap_pkg::INS_CLAMP);
        drScan(1, 32'h0, 2);
        u_tap_master.step(1'b1, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        u_tap_master.step(1'b0, 1'b0, q);
        u_tap_master.resetPulse();
        obs(1'b1, tapInReset, "tapInReset");
        obs(1'b0, extestMode, "extestMode");
        u_tap_master.step(1'b0, 1'b0, q);
        drScan(32, ID_EXP, 32);
        $display("test reset in mid-shift done");
        print_verdict();
    end
endmodule
